// [verilog/operation_mode_pkg.sv]
// constants and types shared by the operation-mode controller
`default_nettype none
package operation_mode_pkg;
   // ------------------------------------------------------------
   // register map (word index on the plain register port)
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] ADDR_CHANNEL_ON = 4'h0;
   localparam logic [3:0] ADDR_HW_CTRL = 4'h1;
   localparam logic [3:0] ADDR_MAP_ZERO = 4'h2;
   localparam logic [3:0] ADDR_MAP_ONE = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_ERROR = 4'h5;
   localparam logic [3:0] ADDR_MONITOR = 4'h6;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int HW_KEEP_ACTIVE = 0;
   localparam int HW_SOFT_RESET = 1;
   localparam int HW_PWM_ZERO = 2;
   localparam int HW_PWM_ONE = 3;
   localparam int HW_OPENLOAD_ON = 4;
   localparam int HW_OPENLOAD_OFF = 5;
   localparam int ST_MODE_LO = 0;
   localparam int ST_BATTERY_UV = 2;
   localparam int ST_LOGIC_LOW = 3;
   localparam int ST_TRANSMIT_ERR = 4;
   // ------------------------------------------------------------
   // reset values and fixed masks
   // ------------------------------------------------------------
   localparam logic [7:0] RST_CHANNEL_ON = 8'h00;
   localparam logic [7:0] RST_HW_CTRL = 8'h00;
   localparam logic [7:0] RST_MAP_ZERO = 8'h04;
   localparam logic [7:0] RST_MAP_ONE = 8'h08;
   localparam logic [7:0] LIMP_CHANNEL_MASK = 8'h0C;
   // ------------------------------------------------------------
   // mode codes as seen in the status register
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_CODE_IDLE = 2'h0;
   localparam logic [1:0] MODE_CODE_LIMP = 2'h1;
   localparam logic [1:0] MODE_CODE_ACTIVE = 2'h2;
   localparam logic [1:0] MODE_CODE_SLEEP = 2'h3;
   typedef enum logic [1:0] {SLEEP, IDLE, ACTIVE, LIMP} op_mode_t;
endpackage : operation_mode_pkg
`default_nettype wire

// [verilog/operation_mode_controller.sv]
// operation-mode controller of an eight-channel high-side switch
//
// Strobed register access and the address map were decided locally.
`default_nettype none
module operation_mode_controller
   import operation_mode_pkg::*;
#(
   parameter int CHANNELS = 8,
   parameter int INPUTS = 2
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic idle_pin,
   input wire logic [INPUTS-1:0] parallel_input_pin,
   input wire logic logic_supply_undervoltage,
   input wire logic logic_supply_low,
   input wire logic battery_below_undervoltage,
   input wire logic battery_above_operative,
   input wire logic [CHANNELS-1:0] channel_fault,
   input wire logic [CHANNELS-1:0] output_status_monitor_bits,
   input wire logic command_done,
   input wire logic command_error,
   input wire logic standard_diag_readout,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   output logic [CHANNELS-1:0] channel_enable,
   output logic [1:0] mode_code,
   output logic diag_enable,
   output logic serial_enable,
   output logic pwm_generator_zero_enable,
   output logic pwm_generator_one_enable,
   output logic on_state_openload_bit,
   output logic off_state_openload_bit
);

   // ------------------------------------------------------------
   // state record
   // ------------------------------------------------------------
   // everything the block remembers lives in this one record
   typedef struct packed {
      logic [INPUTS+4:0] sync_a;
      logic [INPUTS+4:0] sync_b;
      logic [CHANNELS-1:0] monitor_a;
      logic [CHANNELS-1:0] monitor_b;
      op_mode_t mode;
      logic [CHANNELS-1:0] channel_on_bit;
      logic keep_active_bit;
      logic pwm_zero;
      logic pwm_one;
      logic openload_on;
      logic openload_off;
      logic [CHANNELS-1:0] input_map_zero;
      logic [CHANNELS-1:0] input_map_one;
      logic battery_undervoltage_flag;
      logic logic_supply_low_flag;
      logic transmission_error_flag;
      logic limp_first_command;
      logic [CHANNELS-1:0] channel_error_flag;
      logic [CHANNELS-1:0] channel_out;
      logic [DATA_W-1:0] rdata;
   } state_t;

   state_t cur;
   state_t next_cur;

   // mode code for the status field
   function automatic logic [1:0] code_of(input op_mode_t m);
      unique case (m)
         SLEEP: code_of = MODE_CODE_SLEEP;
         IDLE: code_of = MODE_CODE_IDLE;
         ACTIVE: code_of = MODE_CODE_ACTIVE;
         LIMP: code_of = MODE_CODE_LIMP;
      endcase
   endfunction : code_of

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   logic [INPUTS-1:0] in_s;
   logic idle_s;
   logic vdd_uv_s;
   logic vdd_lop_s;
   logic vs_uv_s;
   logic vs_op_s;
   logic any_input;
   logic reg_reset;
   logic wr_ok;
   logic [CHANNELS-1:0] mapped;
   logic [CHANNELS-1:0] drive;
   logic [DATA_W-1:0] status_word;
   // one decode of the soft-reset write, shared by registers and flags
   logic soft_reset_cmd;

   always_comb
   begin
      next_cur = cur;
      // ------------------------------------------------------------
      // synchronisers
      // ------------------------------------------------------------
      // pins and analog comparators pass two flops first
      // only the second stage is decoded; the first may still be settling
      next_cur.sync_a = {parallel_input_pin, idle_pin, logic_supply_undervoltage,
                         logic_supply_low, battery_below_undervoltage,
                         battery_above_operative};
      next_cur.sync_b = cur.sync_a;
      next_cur.monitor_a = output_status_monitor_bits;
      next_cur.monitor_b = cur.monitor_a;
      {in_s, idle_s, vdd_uv_s, vdd_lop_s, vs_uv_s, vs_op_s} = cur.sync_b;
      any_input = |in_s;

      // ------------------------------------------------------------
      // mode selection
      // ------------------------------------------------------------
      // the idle pin outranks everything: low means limp or sleep
      // wake by request
      if (!idle_s)
         next_cur.mode = any_input ? LIMP : SLEEP;
      else if (vdd_uv_s && !any_input)
         next_cur.mode = IDLE;
      else if (any_input || (|cur.channel_on_bit) || cur.keep_active_bit)
         next_cur.mode = ACTIVE;
      else
         next_cur.mode = IDLE;

      // ------------------------------------------------------------
      // register writes
      // ------------------------------------------------------------
      // writes refused outside a live serial port or in limp
      // a write while the logic supply fails could land half-formed, so it is dropped
      // limp is read only
      wr_ok = reg_write && (cur.mode == IDLE || cur.mode == ACTIVE) && !vdd_uv_s;

      // configuration writes
      if (wr_ok)
      begin
         unique case (reg_addr)
            ADDR_CHANNEL_ON: next_cur.channel_on_bit = reg_wdata;
            ADDR_HW_CTRL:
            begin
               next_cur.keep_active_bit = reg_wdata[HW_KEEP_ACTIVE];
               next_cur.pwm_zero = reg_wdata[HW_PWM_ZERO];
               next_cur.pwm_one = reg_wdata[HW_PWM_ONE];
               next_cur.openload_on = reg_wdata[HW_OPENLOAD_ON];
               next_cur.openload_off = reg_wdata[HW_OPENLOAD_OFF];
            end
            ADDR_MAP_ZERO: next_cur.input_map_zero = reg_wdata;
            ADDR_MAP_ONE: next_cur.input_map_one = reg_wdata;
            default: ;
         endcase
      end

      // ------------------------------------------------------------
      // register reset
      // ------------------------------------------------------------
      // the soft-reset bit is a command, never stored, so it reads back 0
      soft_reset_cmd = wr_ok && reg_addr == ADDR_HW_CTRL && reg_wdata[HW_SOFT_RESET];
      // register reset sources; limp and sleep pin registers at default
      // five reset sources
      reg_reset = vdd_uv_s || !idle_s || cur.mode == SLEEP || cur.mode == LIMP
                  || soft_reset_cmd;
      if (reg_reset)
      begin
         next_cur.channel_on_bit = RST_CHANNEL_ON;
         {next_cur.openload_off, next_cur.openload_on, next_cur.pwm_one,
          next_cur.pwm_zero} = RST_HW_CTRL[HW_OPENLOAD_OFF:HW_PWM_ZERO];
         next_cur.keep_active_bit = RST_HW_CTRL[HW_KEEP_ACTIVE];
         next_cur.input_map_zero = RST_MAP_ZERO;
         next_cur.input_map_one = RST_MAP_ONE;
      end

      // ------------------------------------------------------------
      // supply, transmission and channel error flags
      // ------------------------------------------------------------
      // supply flags: soft reset clears, a live condition outside sleep sets and wins
      // soft reset clears supply flags
      if (soft_reset_cmd)
      begin
         next_cur.battery_undervoltage_flag = 1'b0;
         next_cur.logic_supply_low_flag = 1'b0;
      end
      if (standard_diag_readout && vs_op_s && !vs_uv_s)
         next_cur.battery_undervoltage_flag = 1'b0;
      if (standard_diag_readout && !vdd_lop_s)
         next_cur.logic_supply_low_flag = 1'b0;
      if (vs_uv_s && cur.mode != SLEEP)
         next_cur.battery_undervoltage_flag = 1'b1;
      if (vdd_lop_s && cur.mode != SLEEP)
         next_cur.logic_supply_low_flag = 1'b1;

      // transmission error: armed on limp entry, shown to first command
      // a frame error beside a status read is kept: the set wins
      // first limp command flags error
      if (next_cur.mode == LIMP && cur.mode != LIMP)
         next_cur.limp_first_command = 1'b1;
      else if (command_done)
         next_cur.limp_first_command = 1'b0;
      if (reg_read && reg_addr == ADDR_STATUS)
         next_cur.transmission_error_flag = 1'b0;
      if (command_error || (command_done && cur.limp_first_command))
         next_cur.transmission_error_flag = 1'b1;

      // channel error flags: write one to clear, never in idle, set wins
      // idle keeps error flags
      if (wr_ok && cur.mode != IDLE && reg_addr == ADDR_ERROR)
         next_cur.channel_error_flag = cur.channel_error_flag & ~reg_wdata;
      next_cur.channel_error_flag = next_cur.channel_error_flag | channel_fault;

      // ------------------------------------------------------------
      // channel drive
      // ------------------------------------------------------------
      // channel drive; limp uses default maps on channels 2 and 3 only
      // latched errors mask drive so a faulted channel stays off until cleared
      mapped = '0;
      if (in_s[0])
         mapped = mapped | (cur.mode == LIMP ? RST_MAP_ZERO : cur.input_map_zero);
      if (in_s[1])
         mapped = mapped | (cur.mode == LIMP ? RST_MAP_ONE : cur.input_map_one);
      unique case (cur.mode)
         SLEEP, IDLE: drive = '0;
         // reset clears on-bits, inputs still drive
         ACTIVE: drive = cur.channel_on_bit | mapped;
         LIMP: drive = mapped & LIMP_CHANNEL_MASK;
      endcase
      // a battery in undervoltage cannot hold a channel on
      next_cur.channel_out = vs_uv_s ? '0 : (drive & ~cur.channel_error_flag);

      // ------------------------------------------------------------
      // read side
      // ------------------------------------------------------------
      // status word; limp forces supply flags and mode field
      status_word = '0;
      status_word[ST_MODE_LO +: 2] = code_of(cur.mode);
      status_word[ST_BATTERY_UV] = cur.battery_undervoltage_flag || cur.mode == LIMP;
      status_word[ST_LOGIC_LOW] = cur.logic_supply_low_flag || cur.mode == LIMP;
      status_word[ST_TRANSMIT_ERR] = cur.transmission_error_flag || cur.limp_first_command;

      // read port: data in the cycle after the strobe only
      next_cur.rdata = '0;
      if (reg_read && serial_enable)
      begin
         unique case (reg_addr)
            ADDR_CHANNEL_ON: next_cur.rdata = cur.channel_on_bit;
            ADDR_HW_CTRL: next_cur.rdata = {2'h0, cur.openload_off, cur.openload_on,
                                            cur.pwm_one, cur.pwm_zero, 1'b0,
                                            cur.keep_active_bit};
            ADDR_MAP_ZERO: next_cur.rdata = cur.input_map_zero;
            ADDR_MAP_ONE: next_cur.rdata = cur.input_map_one;
            ADDR_STATUS: next_cur.rdata = status_word;
            ADDR_ERROR: next_cur.rdata = cur.channel_error_flag;
            ADDR_MONITOR: next_cur.rdata = cur.monitor_b;
            default: next_cur.rdata = '0;
         endcase
      end
   end

   // serial port alive in idle, active, limp with logic supply present
   // serial gated by logic supply
   assign serial_enable = cur.mode != SLEEP && !cur.sync_b[3];

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   // synchronous reset; the maps reload their defaults, not zero
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         cur <= '0;
         cur.mode <= SLEEP;
         cur.input_map_zero <= RST_MAP_ZERO;
         cur.input_map_one <= RST_MAP_ONE;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign reg_rdata = cur.rdata;
   assign channel_enable = cur.channel_out;
   // mode field and diagnosis enable decode straight from the mode register; pwm enables follow their bits
   assign mode_code = code_of(cur.mode);
   assign diag_enable = cur.mode == ACTIVE || cur.mode == LIMP;
   assign pwm_generator_zero_enable = cur.pwm_zero;
   assign pwm_generator_one_enable = cur.pwm_one;
   // gated again here so a stale open-load bit never shows in limp
   // limp zeroes open-load bits
   assign on_state_openload_bit = cur.openload_on && cur.mode != LIMP;
   assign off_state_openload_bit = cur.openload_off && cur.mode != LIMP;

endmodule : operation_mode_controller
`default_nettype wire

// [dv/mode_monitor.sv]
// assertion checker for the operation-mode controller ports
`default_nettype none
module mode_monitor
   import operation_mode_pkg::*;
#(
   parameter int CHANNELS = 8
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic [CHANNELS-1:0] channel_enable,
   input wire logic [1:0] mode_code,
   input wire logic diag_enable,
   input wire logic serial_enable,
   input wire logic on_state_openload_bit,
   input wire logic off_state_openload_bit
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // ----
   // steps
   // ----
   // two samples, since channel drive lags the mode by one edge
   sequence held(logic [1:0] m);
      mode_code == m && $past(mode_code) == m;
   endsequence
   sequence limp_write;
      reg_write && reg_addr == ADDR_CHANNEL_ON && mode_code == MODE_CODE_LIMP;
   endsequence
   sequence limp_readback;
      reg_read && reg_addr == ADDR_CHANNEL_ON && mode_code == MODE_CODE_LIMP;
   endsequence
   // ----
   // checks
   // ----
   a_sleep_quiet:
   assert property (held(MODE_CODE_SLEEP) |-> channel_enable == '0 && !diag_enable)
      else $error("channel driven in sleep");
   a_sleep_serial:
   assert property (mode_code == MODE_CODE_SLEEP |-> !serial_enable)
      else $error("serial port live in sleep");
   a_idle_quiet:
   assert property (held(MODE_CODE_IDLE) |-> channel_enable == '0)
      else $error("channel driven in idle");
   a_idle_nodiag:
   assert property (mode_code == MODE_CODE_IDLE |-> !diag_enable)
      else $error("diagnosis on in idle");
   a_serial_off_zero:
   assert property (reg_read && !serial_enable |=> reg_rdata == '0)
      else $error("read answered with serial off");
   a_limp_mask:
   assert property (held(MODE_CODE_LIMP) |-> (8'(channel_enable) & ~LIMP_CHANNEL_MASK) == 0)
      else $error("channel outside limp mask on");
   a_limp_openload:
   assert property (held(MODE_CODE_LIMP) |-> !on_state_openload_bit && !off_state_openload_bit)
      else $error("open-load control set in limp");
   a_limp_status:
   assert property (reg_read && reg_addr == ADDR_STATUS && mode_code == MODE_CODE_LIMP
      && serial_enable |=> reg_rdata[1:0] == MODE_CODE_LIMP && reg_rdata[3:2] == 2'h3)
      else $error("limp status field wrong");
   a_limp_readonly:
   assert property (limp_write ##2 limp_readback |=> reg_rdata == '0)
      else $error("write accepted in limp");
endmodule : mode_monitor
`default_nettype wire

// [dv/host_model.sv]
// host model driving the controller pins and register port
`default_nettype none
module host_model
   import operation_mode_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [DATA_W-1:0] reg_rdata,
   output logic idle_pin,
   output logic [1:0] parallel_input_pin,
   output logic logic_supply_undervoltage,
   output logic battery_below_undervoltage,
   output logic battery_above_operative,
   output logic command_done,
   output logic standard_diag_readout,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wdata,
   output logic reg_write,
   output logic reg_read
);
   timeunit 1ns;
   timeprecision 1ns;
   // quiet host at power-up
   initial
   begin
      {idle_pin, parallel_input_pin, logic_supply_undervoltage} = 4'h0;
      {battery_below_undervoltage, battery_above_operative} = 2'h1;
      {command_done, standard_diag_readout, reg_write, reg_read} = 4'h0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
   end
   // commands go out on the next clock edge, whatever the mode
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge sys_clk);
      reg_write <= 1'h0;
      reg_wdata <= ~d; // stale data never looks valid
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge sys_clk);
      reg_read <= 1'h0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask : rd
   // one-cycle end-of-command or diagnosis readout strobe
   task automatic strobe(input logic diag);
      @(posedge sys_clk);
      command_done <= !diag;
      standard_diag_readout <= diag;
      @(posedge sys_clk);
      command_done <= 1'h0;
      standard_diag_readout <= 1'h0;
   endtask : strobe
   // sup is {logic uv, battery below uv, battery above operative}
   task automatic pins(input logic idle, input logic [1:0] inp, input logic [2:0] sup);
      @(posedge sys_clk);
      idle_pin <= idle;
      parallel_input_pin <= inp;
      {logic_supply_undervoltage, battery_below_undervoltage, battery_above_operative} <= sup;
   endtask : pins
endmodule : host_model
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the operation-mode controller
`default_nettype none
module tb;
   import operation_mode_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic idle_pin, logic_supply_undervoltage, battery_below_undervoltage, reg_write, reg_read;
   logic battery_above_operative, command_done, standard_diag_readout, diag_enable;
   logic serial_enable, pwm_generator_zero_enable, pwm_generator_one_enable;
   logic on_state_openload_bit, off_state_openload_bit;
   logic [1:0] parallel_input_pin, mode_code;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
   logic [7:0] channel_enable;
   logic logic_supply_low = 1'h0;
   logic [7:0] channel_fault = 8'h00;
   logic [7:0] output_status_monitor_bits = 8'h00;
   logic [3:0] ctl_pins;
   // control-register pins gathered for one compare
   assign ctl_pins = {off_state_openload_bit, on_state_openload_bit,
                      pwm_generator_one_enable, pwm_generator_zero_enable};
   int err_total = 0;
   int n_compared = 0;
   always #50 sys_clk = ~sys_clk;
   // frame-error input tied quiet; bad frames are not modelled here
   operation_mode_controller dut (.sys_clk, .sys_rst, .idle_pin, .parallel_input_pin,
      .logic_supply_undervoltage, .logic_supply_low, .battery_below_undervoltage,
      .battery_above_operative, .channel_fault, .output_status_monitor_bits,
      .command_done, .command_error(1'h0), .standard_diag_readout, .reg_addr, .reg_wdata,
      .reg_write, .reg_read, .reg_rdata, .channel_enable, .mode_code, .diag_enable,
      .serial_enable, .pwm_generator_zero_enable, .pwm_generator_one_enable,
      .on_state_openload_bit, .off_state_openload_bit);
   host_model host (.sys_clk, .reg_rdata, .idle_pin, .parallel_input_pin,
      .logic_supply_undervoltage, .battery_below_undervoltage, .battery_above_operative,
      .command_done, .standard_diag_readout, .reg_addr, .reg_wdata, .reg_write, .reg_read);
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // bounded wait for a mode, plus one edge for the channel drive
   task automatic wait_mode(input logic [1:0] m);
      for (int i = 0; i < 20; i++)
      begin
         @(negedge sys_clk);
         if (mode_code === m)
            break;
      end
      chk("mode", {6'h00, mode_code}, {6'h00, m});
      if (mode_code !== m)
         report_and_stop();
      @(negedge sys_clk);
   endtask : wait_mode
   initial
   begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'h0;
      wait_mode(MODE_CODE_SLEEP);
      host.rd(ADDR_CHANNEL_ON, d);
      chk("sleep read", d, 8'h00);
      $display("test sleep done");
      host.pins(1'h1, 2'h0, 3'h1);
      wait_mode(MODE_CODE_IDLE);
      host.wr(ADDR_CHANNEL_ON, 8'h81);
      wait_mode(MODE_CODE_ACTIVE);
      chk("drive", channel_enable, 8'h81);
      host.wr(ADDR_CHANNEL_ON, 8'h00);
      wait_mode(MODE_CODE_IDLE);
      chk("drive", channel_enable, 8'h00);
      // keep-active with every control bit but soft reset set, then a fault and a low logic supply
      host.wr(ADDR_HW_CTRL, 8'h3D);
      wait_mode(MODE_CODE_ACTIVE);
      host.rd(ADDR_HW_CTRL, d);
      chk("ctrl", d, 8'h3D);
      chk("pwm ol", {4'h0, ctl_pins}, 8'h0F);
      @(posedge sys_clk);
      channel_fault <= 8'h10;
      logic_supply_low <= 1'h1;
      @(posedge sys_clk);
      channel_fault <= 8'h00;
      repeat (4) @(posedge sys_clk);
      logic_supply_low <= 1'h0;
      repeat (10) @(negedge sys_clk);
      chk("mode", {6'h00, mode_code}, {6'h00, MODE_CODE_ACTIVE});
      host.rd(ADDR_STATUS, d);
      chk("status", d, 8'h0A);
      host.wr(ADDR_HW_CTRL, 8'h02);
      host.rd(ADDR_HW_CTRL, d);
      chk("ctrl", d, RST_HW_CTRL);
      chk("pwm ol", {4'h0, ctl_pins}, 8'h00);
      host.rd(ADDR_STATUS, d);
      chk("status", d, {6'h00, MODE_CODE_IDLE});
      host.rd(ADDR_ERROR, d);
      chk("errors", d, 8'h10);
      wait_mode(MODE_CODE_IDLE);
      host.wr(ADDR_ERROR, 8'hFF);
      host.rd(ADDR_ERROR, d);
      chk("errors", d, 8'h10);
      $display("test modes done");
      host.wr(ADDR_CHANNEL_ON, 8'h01);
      wait_mode(MODE_CODE_ACTIVE);
      host.wr(ADDR_ERROR, 8'h10);
      host.rd(ADDR_ERROR, d);
      chk("errors", d, 8'h00);
      host.pins(1'h1, 2'h0, 3'h2);
      repeat (6) @(negedge sys_clk);
      chk("drive", channel_enable, 8'h00);
      host.rd(ADDR_STATUS, d);
      chk("status", d, 8'h06);
      host.pins(1'h1, 2'h0, 3'h1);
      repeat (6) @(negedge sys_clk);
      host.rd(ADDR_STATUS, d);
      chk("status", d, 8'h06);
      host.strobe(1'h1);
      host.rd(ADDR_STATUS, d);
      chk("status", d, 8'h02);
      $display("test battery done");
      host.wr(ADDR_MAP_ZERO, 8'h00);
      host.wr(ADDR_MAP_ONE, 8'h00);
      host.wr(ADDR_CHANNEL_ON, 8'h00);
      host.pins(1'h1, 2'h2, 3'h1);
      repeat (6) @(negedge sys_clk);
      chk("mode", {6'h00, mode_code}, {6'h00, MODE_CODE_ACTIVE});
      chk("drive", channel_enable, 8'h00);
      host.pins(1'h1, 2'h0, 3'h5);
      wait_mode(MODE_CODE_IDLE);
      chk("serial", {7'h00, serial_enable}, 8'h00);
      host.pins(1'h1, 2'h0, 3'h1);
      repeat (4) @(negedge sys_clk);
      host.rd(ADDR_MAP_ZERO, d);
      chk("map", d, RST_MAP_ZERO);
      $display("test supply done");
      // open-load bits armed in idle so limp entry has something to clear
      host.wr(ADDR_HW_CTRL, 8'h30);
      @(negedge sys_clk);
      chk("pwm ol", {4'h0, ctl_pins}, 8'h0C);
      host.pins(1'h0, 2'h1, 3'h1);
      wait_mode(MODE_CODE_LIMP);
      chk("pwm ol", {4'h0, ctl_pins}, 8'h00);
      chk("drive", channel_enable, 8'h04);
      host.rd(ADDR_STATUS, d);
      chk("status", d, 8'h1D);
      host.strobe(1'h0);
      host.rd(ADDR_STATUS, d);
      chk("status", d, 8'h1D);
      host.rd(ADDR_STATUS, d);
      chk("status", d, 8'h0D);
      host.wr(ADDR_CHANNEL_ON, 8'hFF);
      host.rd(ADDR_CHANNEL_ON, d);
      chk("on bits", d, 8'h00);
      host.rd(ADDR_HW_CTRL, d);
      chk("ctrl", d, 8'h00);
      chk("drive", channel_enable, 8'h04);
      // a fault in limp still latches and masks; the monitor still reads
      @(posedge sys_clk);
      channel_fault <= 8'h04;
      output_status_monitor_bits <= 8'h04;
      @(posedge sys_clk);
      channel_fault <= 8'h00;
      host.rd(ADDR_ERROR, d);
      chk("errors", d, 8'h04);
      chk("drive", channel_enable, 8'h00);
      host.rd(ADDR_MONITOR, d);
      chk("monitor", d, 8'h04);
      host.pins(1'h0, 2'h0, 3'h1);
      wait_mode(MODE_CODE_SLEEP);
      chk("drive", channel_enable, 8'h00);
      $display("test limp done");
      report_and_stop();
   end
endmodule : tb
bind operation_mode_controller mode_monitor #(.CHANNELS(CHANNELS)) mon (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .channel_enable(channel_enable), .mode_code(mode_code),
   .diag_enable(diag_enable), .serial_enable(serial_enable),
   .on_state_openload_bit(on_state_openload_bit),
   .off_state_openload_bit(off_state_openload_bit));
`default_nettype wire
